// ---- pkg/cps_map.vh ----
// constants for the configuration port sequencer
`ifndef CPS_MAP_VH
`define CPS_MAP_VH
// clock rate in MHz and figures as printed
`define CPS_CLK_MHZ 250
`define CPS_RST_MIN_NS 200
`define CPS_RST_MIN_CYC ((`CPS_RST_MIN_NS * `CPS_CLK_MHZ + 999) / 1000)
`define CPS_DONE_IO_CONFIG_CLOCK 49
// size-dependent clear waits in us
`define CPS_WAIT_SMALL_US 600
`define CPS_WAIT_MID_US 800
`define CPS_WAIT_LARGE_US 1200
`define CPS_US_CYC(us) ((us) * `CPS_CLK_MHZ)
// density selector codes
`define CPS_DEN_SMALL 2'h0
`define CPS_DEN_MID 2'h1
`define CPS_DEN_LARGE 2'h2
// image layout: a run of bytes, then an end-of-image marker
`define CPS_IMAGE_BYTES 16'h0010
`define CPS_END_MARK 8'hA5
`define CPS_CNT_W 20
`endif

// ---- core/cps_skid.v ----
// two-entry buffer with valid and ready on both sides
`include "cps_map.vh"
module cps_skid (
  // clock and reset
  input wire mclk,
  input wire arst_n,
  input wire clr,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [7:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [7:0] out_data
);
  reg [7:0] mem_q [0:1];
  reg wr_q;
  reg rd_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;
  // ======================================
  // handshakes
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // storage and pointers
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
    end else if (clr) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ---- core/cps_seq.v ----
// configuration port start-up sequencer
// Contract
// [RULE1] a low config reset of at least 200 ns restarts configuration
// [RULE2] at least 49 config clocks after completion before user pins turn on
// [RULE3] host waits 600/800/1200 us after reset release before first clock
// [RULE4] device clears configuration memory during that wait before taking data
// [RULE5] read data bits launch on the falling config clock edge
// [RULE6] completion stays low from reset until a full valid image loads
`include "cps_map.vh"
module cps_seq (
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // configuration pins
  input wire config_reset_n,
  input wire config_clock,
  input wire spi_sel_n,
  input wire spi_mosi,
  output reg spi_miso,
  output reg spi_miso_oe,
  output reg config_complete,
  output reg user_io_enable,
  // density strap
  input wire [1:0] density,
  // image byte stream to the fabric
  output wire img_valid,
  input wire img_ready,
  output wire [7:0] img_data,
  // status
  output wire clearing,
  output wire busy
);
  localparam [2:0] ST_RESET = 3'h0;
  localparam [2:0] ST_CLEAR = 3'h1;
  localparam [2:0] ST_LOAD = 3'h2;
  localparam [2:0] ST_WAKE = 3'h3;
  localparam [2:0] ST_USER = 3'h4;
  localparam [2:0] ST_FAIL = 3'h5;
  // counts cut to their counter widths on purpose
  localparam integer RST_CYC_I = `CPS_RST_MIN_CYC;
  localparam integer WAKE_CYC_I = `CPS_DONE_IO_CONFIG_CLOCK;
  localparam [8:0] RST_CYC = RST_CYC_I[8:0];
  localparam [5:0] WAKE_CYC = WAKE_CYC_I[5:0];
  parameter [`CPS_CNT_W-1:0] WAIT_SMALL = `CPS_US_CYC(`CPS_WAIT_SMALL_US);
  parameter [`CPS_CNT_W-1:0] WAIT_MID = `CPS_US_CYC(`CPS_WAIT_MID_US);
  parameter [`CPS_CNT_W-1:0] WAIT_LARGE = `CPS_US_CYC(`CPS_WAIT_LARGE_US);
  // ======================================
  // pin synchronisers
  reg [1:0] rst_s_q;
  reg [1:0] clk_s_q;
  reg [1:0] sel_s_q;
  reg [1:0] mosi_s_q;
  reg clk_d1_q;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s_q <= 2'h3;
      clk_s_q <= 2'h0;
      sel_s_q <= 2'h3;
      mosi_s_q <= 2'h0;
      clk_d1_q <= 1'b0;
    end else begin
      rst_s_q <= {rst_s_q[0], config_reset_n};
      clk_s_q <= {clk_s_q[0], config_clock};
      sel_s_q <= {sel_s_q[0], spi_sel_n};
      mosi_s_q <= {mosi_s_q[0], spi_mosi};
      clk_d1_q <= clk_s_q[1];
    end
  end
  wire cfg_rst_n = rst_s_q[1];
  wire sel_act = ~sel_s_q[1];
  wire clk_rise = clk_s_q[1] & ~clk_d1_q;
  wire clk_fall = ~clk_s_q[1] & clk_d1_q;
  // ======================================
  // density to wait count
  function [`CPS_CNT_W-1:0] wait_of;
    input [1:0] den;
    begin
      case (den)
        `CPS_DEN_SMALL: wait_of = WAIT_SMALL;
        `CPS_DEN_MID: wait_of = WAIT_MID;
        default: wait_of = WAIT_LARGE;
      endcase
    end
  endfunction
  // ======================================
  // sequencer
  reg [2:0] st_q;
  reg [8:0] low_q;
  reg [`CPS_CNT_W-1:0] cnt_q;
  reg [1:0] den_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg [15:0] nbyte_q;
  reg byte_v_q;
  reg [7:0] byte_q;
  reg [7:0] rd_q;
  wire buf_ready;
  wire restart = (low_q >= RST_CYC) & cfg_rst_n; // RULE1
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      low_q <= 9'h000;
    end else if (cfg_rst_n) begin
      low_q <= 9'h000;
    end else if (low_q != 9'h1FF) begin
      low_q <= low_q + 9'h001;
    end
  end
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_RESET;
      cnt_q <= {`CPS_CNT_W{1'b0}};
      den_q <= `CPS_DEN_SMALL;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      nbyte_q <= 16'h0000;
      byte_v_q <= 1'b0;
      byte_q <= 8'h00;
      config_complete <= 1'b0;
      user_io_enable <= 1'b0;
    end else if (restart) begin
      st_q <= ST_CLEAR; // RULE1
      den_q <= density;
      cnt_q <= wait_of(density);
      bit_q <= 3'h0;
      nbyte_q <= 16'h0000;
      byte_v_q <= 1'b0;
      config_complete <= 1'b0; // RULE6
      user_io_enable <= 1'b0;
    end else begin
      if (byte_v_q & buf_ready) begin
        byte_v_q <= 1'b0;
      end
      case (st_q)
        ST_RESET: begin
          if (cfg_rst_n) begin
            st_q <= ST_CLEAR;
            den_q <= density;
            cnt_q <= wait_of(density);
          end
        end
        ST_CLEAR: begin
          // memory cleared while counting; clocks now are ignored
          if (cnt_q == {`CPS_CNT_W{1'b0}}) begin
            st_q <= ST_LOAD; // RULE4
          end else begin
            cnt_q <= cnt_q - {{(`CPS_CNT_W-1){1'b0}}, 1'b1}; // RULE3
          end
        end
        ST_LOAD: begin
          if (clk_rise & sel_act & ~(byte_v_q & ~buf_ready)) begin
            sh_q <= {sh_q[6:0], mosi_s_q[1]};
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              if (nbyte_q == `CPS_IMAGE_BYTES) begin
                if ({sh_q[6:0], mosi_s_q[1]} == `CPS_END_MARK) begin
                  st_q <= ST_WAKE;
                  config_complete <= 1'b1; // RULE6
                  cnt_q <= {`CPS_CNT_W{1'b0}};
                end else begin
                  st_q <= ST_FAIL;
                end
              end else begin
                byte_q <= {sh_q[6:0], mosi_s_q[1]};
                byte_v_q <= 1'b1;
                nbyte_q <= nbyte_q + 16'h0001;
              end
            end
          end
        end
        ST_WAKE: begin
          if (clk_rise) begin
            cnt_q <= cnt_q + {{(`CPS_CNT_W-1){1'b0}}, 1'b1};
            if (cnt_q[5:0] == WAKE_CYC - 6'h01) begin
              st_q <= ST_USER; // RULE2
              user_io_enable <= 1'b1;
            end
          end
        end
        ST_USER: st_q <= ST_USER;
        ST_FAIL: st_q <= ST_FAIL;
        default: st_q <= ST_RESET;
      endcase
    end
  end
  // ======================================
  // read-back: status byte shifted out on falling clock edges
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= 8'h00;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= sel_act & (st_q != ST_CLEAR);
      if (~sel_act) begin
        rd_q <= {config_complete, user_io_enable, st_q == ST_FAIL, st_q, den_q};
      end else if (clk_fall) begin
        spi_miso <= rd_q[7]; // RULE5
        rd_q <= {rd_q[6:0], 1'b0};
      end
    end
  end
  // ======================================
  // image byte buffer
  cps_skid u_buf (
    .mclk(mclk),
    .arst_n(arst_n),
    .clr(restart),
    .in_valid(byte_v_q),
    .in_ready(buf_ready),
    .in_data(byte_q),
    .out_valid(img_valid),
    .out_ready(img_ready),
    .out_data(img_data)
  );
  assign clearing = (st_q == ST_CLEAR);
  assign busy = (st_q != ST_USER);
endmodule

// ---- verif/cps_host.sv ----
// host model that drives the configuration pins
module cps_host (
  // clock
  input wire logic mclk,
  // pins toward the device
  output logic config_reset_n,
  output logic config_clock,
  output logic spi_sel_n,
  output logic spi_mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // idle levels, clock still outside frames
  initial begin
    config_reset_n = 1'b1;
    config_clock = 1'b0;
    spi_sel_n = 1'b1;
    spi_mosi = 1'b1;
  end
  // low reset pulse of n mclk cycles
  task pulse(input int n);
    spi_sel_n = 1'b1;
    config_reset_n = 1'b0;
    repeat (n) @(negedge mclk);
    config_reset_n = 1'b1;
  endtask
  // one bit in 32 ns, data set while the clock is low
  task bit_x(input logic b);
    spi_sel_n = 1'b0;
    spi_mosi = b;
    repeat (4) @(negedge mclk);
    config_clock = 1'b1;
    repeat (4) @(negedge mclk);
    config_clock = 1'b0;
  endtask
  // deselect for n mclk cycles so the status byte reloads
  task deselect(input int n);
    spi_sel_n = 1'b1;
    repeat (n) @(negedge mclk);
  endtask
endmodule

// ---- verif/cps_seq_assertions.sv ----
// concurrent checks on the sequencer ports
module cps_seq_assertions (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // watched ports
  input wire logic config_reset_n,
  input wire logic config_clock,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic config_complete,
  input wire logic user_io_enable,
  input wire logic img_valid,
  input wire logic clearing
);
  // ====================
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic [7:0] low_q;
  logic [7:0] rise_q;
  logic [3:0] fall_q;
  logic clk_q;
  // reset low length, clock rises since completion, cycles since a fall
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      low_q <= 8'h00;
      rise_q <= 8'h00;
      fall_q <= 4'h0;
      clk_q <= 1'b0;
    end else begin
      clk_q <= config_clock;
      low_q <= config_reset_n ? 8'h00 : low_q + {7'h00, low_q != 8'hFF};
      rise_q <= !config_complete ? 8'h00 : rise_q + {7'h00, config_clock & !clk_q};
      fall_q <= (clk_q & !config_clock) ? 4'h0 : fall_q + {3'h0, fall_q != 4'hF};
    end
  end
  a_restart_clears: assert property ($rose(config_reset_n) && low_q > 8'h34 |-> ##[1:6] clearing)
    else $error("long reset pulse did not start the clear wait");
  a_short_ignored: assert property ($rose(config_reset_n) && low_q < 8'h28 && !clearing |=> !clearing [*6])
    else $error("short reset pulse started a clear wait");
  a_clear_quiet: assert property (clearing && $past(clearing) |-> !img_valid && !config_complete)
    else $error("data or completion during the clear wait");
  a_io_after_count: assert property ($rose(user_io_enable) |-> config_complete && rise_q >= 8'd49)
    else $error("user pins on before enough clock cycles");
  a_io_on_time: assert property (config_complete && rise_q == 8'd49 |-> ##[0:8] user_io_enable)
    else $error("user pins late after completion");
  a_miso_fall: assert property (spi_miso_oe && $past(spi_miso_oe) && $changed(spi_miso) |-> fall_q <= 4'h5)
    else $error("read bit not launched from a clock fall");
  a_io_needs_done: assert property (!config_complete |-> !user_io_enable)
    else $error("user pins on without completion");
  // main scenarios seen
  cover property ($rose(clearing));
  cover property ($rose(config_complete));
  cover property ($rose(user_io_enable));
endmodule
bind cps_seq cps_seq_assertions chk (.mclk, .arst_n, .config_reset_n, .config_clock, .spi_miso,
  .spi_miso_oe, .config_complete, .user_io_enable, .img_valid, .clearing);

// ---- verif/config_port_sequencer_test.sv ----
// random and corner tests of the configuration port sequencer
module config_port_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, arst_n, config_reset_n, config_clock, spi_sel_n, spi_mosi, spi_miso, spi_miso_oe;
  logic config_complete, user_io_enable, img_valid, img_ready, clearing, busy, hold;
  logic [1:0] density;
  logic [7:0] img_data;
  logic [7:0] sent[16];
  logic [7:0] got[$];
  int errors, n_compared, seed, n, clr_cnt;
  logic [7:0] r;
  localparam logic [19:0] W_SMALL = 20'd100;
  localparam logic [19:0] W_MID = 20'd150;
  localparam logic [19:0] W_LARGE = 20'd200;
  // ====================
  // 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  cps_host host (.mclk, .config_reset_n, .config_clock, .spi_sel_n, .spi_mosi);
  cps_seq #(.WAIT_SMALL(W_SMALL), .WAIT_MID(W_MID), .WAIT_LARGE(W_LARGE)) dut (.mclk, .arst_n,
    .config_reset_n, .config_clock, .spi_sel_n, .spi_mosi, .spi_miso, .spi_miso_oe,
    .config_complete, .user_io_enable, .density, .img_valid, .img_ready, .img_data, .clearing, .busy);
  // sink with random stalls, byte capture, clear length
  always @(negedge mclk) img_ready <= !hold && (($random(seed) & 1) != 0);
  always @(posedge mclk) if (img_valid === 1'b1 && img_ready === 1'b1) got.push_back(img_data);
  always @(posedge mclk) if (clearing === 1'b1) clr_cnt++;
  function int wait_of(input int d);
    return d == 0 ? W_SMALL : (d == 1 ? W_MID : W_LARGE);
  endfunction
  // status byte in user mode: complete, user pins, no fail, user state, density
  function logic [7:0] status_of(input int d);
    return {2'h3, 1'b0, 3'h4, d[1:0]};
  endfunction
  task chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task test_done();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 400) begin
      @(negedge mclk);
      n++;
    end
    chk("wait bound", 1, n < 400);
    if (n >= 400) test_done();
  endtask
  task xfer(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) host.bit_x(b[i]);
  endtask
  // deselect to reload the status byte, then eight clock falls shift it out
  task readback();
    host.deselect(4);
    for (int i = 0; i < 8; i++) begin
      host.bit_x(1'b0);
      repeat (4) @(negedge mclk);
      r = {r[6:0], spi_miso};
    end
  endtask
  // restart, wait out the clear, send an image of random bytes
  task image(input int d);
    density = d[1:0];
    got.delete();
    host.pulse(60);
    clr_cnt = 0;
    wait_for(clearing, 1'b1);
    xfer(8'hFF);
    wait_for(clearing, 1'b0);
    chk("clear length", 1, clr_cnt >= wait_of(d) && clr_cnt <= wait_of(d) + 4);
    for (int i = 0; i < 16; i++) begin
      sent[i] = $random(seed);
      xfer(sent[i]);
    end
    xfer(8'hA5);
    repeat (8) @(negedge mclk);
  endtask
  initial begin
    seed = 12;
    arst_n = 1'b0;
    density = 2'h0;
    hold = 1'b0;
    repeat (6) @(negedge mclk);
    arst_n = 1'b1;
    for (int d = 0; d < 4; d++) begin
      image(d);
      chk("complete", 1, config_complete);
      for (int i = 0; i < 16; i++) chk("image byte", sent[i], got[i]);
      for (n = 0; user_io_enable !== 1'b1 && n < 60; n++) host.bit_x(1'b0);
      chk("io delay", 1, n >= 49 && n <= 50);
      if (n >= 60) test_done();
      chk("busy", 0, busy);
      readback();
      chk("status byte", status_of(d), r);
      chk("miso enable", 1, spi_miso_oe);
      $display("density %0d done", d);
    end
    arst_n = 1'b0;
    repeat (2) @(negedge mclk);
    chk("reset complete", 0, config_complete);
    chk("reset io", 0, user_io_enable);
    arst_n = 1'b1;
    wait_for(clearing, 1'b1);
    wait_for(clearing, 1'b0);
    $display("mid-run reset done");
    clr_cnt = 0;
    host.pulse(20);
    repeat (20) @(negedge mclk);
    chk("short pulse clear", 0, clr_cnt);
    $display("short pulse done");
    hold = 1'b1;
    image(0);
    chk("complete when bytes lost", 0, config_complete);
    chk("buffer fill", 0, got.size());
    chk("busy when stalled", 1, busy);
    hold = 1'b0;
    for (n = 0; got.size() < 3 && n < 100; n++) @(negedge mclk);
    chk("buffer drain", 3, got.size());
    for (int i = 0; i < 3; i++) chk("drained byte", sent[i], got[i]);
    chk("buffer empty", 0, img_valid);
    $display("full buffer done");
    test_done();
  end
endmodule
